// ==== verilog/upstream_request_map_framer.sv ====
// Request block framer, map segment receiver and probe packetiser
`timescale 1ns/10ps
module upstream_request_map_framer import framer_pkg::*; #(
  parameter int MAX_BLK = MAX_BLOCKS,
  parameter int FLUSH_CYC = FLUSH_CYCLES,
  parameter int MAP_MAX = MAP_MAX_BYTES,
  parameter int ELEM_OFS = MAP_ELEM_OFFSET,
  parameter int PROBE_MAX = PROBE_PKT_MAX,
  parameter int CH_W = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_piggyback,
  input wire logic req_frag_concat,
  input wire logic req_byte_units,
  input wire logic [2:0] req_cluster,
  input wire logic req_cluster_valid,
  input wire logic [3:0] req_interval_usage_code,
  input wire logic [15:0] req_size,
  input wire logic [13:0] req_scheduled_identifier,
  input wire logic [13:0] req_embedded_identifier,
  input wire logic req_embedded_present,
  input wire logic [31:0] req_start_minislot,
  input wire logic [31:0] req_session,
  output logic req_dropped,
  output logic rq_out_valid,
  input wire logic rq_out_ready,
  output logic [7:0] rq_out_data,
  output logic rq_out_first,
  output logic rq_out_last,
  output logic [7:0] rq_out_blocks,
  output logic [1:0] rq_seg_flags,
  input wire logic map_valid,
  input wire logic [7:0] map_data,
  input wire logic map_first,
  input wire logic map_last,
  input wire logic [CH_W-1:0] map_channel,
  input wire logic map_seg_begin,
  input wire logic map_seg_end,
  input wire logic [7:0] map_seg_count,
  output logic mo_valid,
  output logic [7:0] mo_data,
  output logic mo_first,
  output logic mo_last,
  output logic [CH_W-1:0] mo_channel,
  output logic map_null_seen,
  output logic map_error,
  input wire logic probe_in_valid,
  output logic probe_in_ready,
  input wire logic [7:0] probe_in_data,
  input wire logic probe_in_hdr,
  input wire logic probe_in_end,
  output logic probe_out_valid,
  input wire logic probe_out_ready,
  output logic [7:0] probe_out_data,
  output logic probe_out_hdr,
  output logic probe_out_first,
  output logic probe_out_last,
  output logic probe_out_unit_start,
  output logic probe_out_unit_end,
  output logic probe_error
);
  localparam int NB_W = $clog2(MAX_BLK + 1);
  localparam int TM_W = $clog2(FLUSH_CYC + 1);
  localparam int MP_W = $clog2(MAP_MAX + 1);
  localparam int PC_W = $clog2(PROBE_MAX + 1);

  typedef struct packed {
    req_state_t st;
    logic [BLK_BITS-1:0] blk;
    logic [3:0] idx;
    logic [NB_W-1:0] nblk;
    logic [TM_W-1:0] tmr;
    logic first;
    logic endpkt;
    logic drop_p;
    logic [MP_W-1:0] m_pos;
    logic [1:0] m_ph;
    logic [23:0] m_sh;
    logic m_skip;
    logic mo_v;
    logic [7:0] mo_d;
    logic mo_f;
    logic mo_l;
    logic [CH_W-1:0] mo_ch;
    logic m_err;
    logic m_null;
    logic po_v;
    logic [7:0] po_d;
    logic po_h;
    logic po_f;
    logic po_l;
    logic po_us;
    logic po_ue;
    logic [PC_W-1:0] p_cnt;
    logic p_mid;
    logic p_err;
  } state_t;

  state_t r_reg;
  state_t r_next;

  logic drop;
  logic b_s_valid;
  logic b_s_ready;
  logic b_m_valid;
  logic b_m_ready;
  logic [BLK_BITS-1:0] blk_in;
  logic [BLK_BITS-1:0] b_m_data;
  logic more;
  logic tmr_done;
  logic m_skip;
  logic [MP_W-1:0] m_pos;
  logic [1:0] m_ph;
  logic m_bad;
  logic m_is_null;
  logic p_take;
  logic p_pkt_end;

  function automatic logic [BLK_BITS-1:0] build_block(
    input logic piggyback,
    input logic byte_units,
    input logic [2:0] cluster,
    input logic cluster_valid,
    input logic [3:0] usage_code,
    input logic [15:0] size,
    input logic [13:0] sched,
    input logic [13:0] emb,
    input logic emb_present,
    input logic [31:0] start,
    input logic [31:0] session
  );
    logic [7:0] status;
    status = {HDR_VERSION_1, cluster, 3'h0};
    status[ST_VALID_BIT] = cluster_valid;
    status[ST_UNITS_BIT] = byte_units;
    status[ST_TYPE_BIT] = piggyback;
    build_block = {
      status,
      1'b0,
      usage_code,
      size,
      sched,
      emb_present ? emb : 14'h0000,
      start,
      session,
      {BLK_PAD_BITS{1'b0}}
    };
  endfunction

  function automatic logic [3:0] usage_of(input logic [31:0] elem);
    usage_of = elem[17:14];
  endfunction

  assign drop = req_piggyback && req_frag_concat;
  assign b_s_valid = req_valid && !drop;
  assign req_ready = drop || b_s_ready;

  assign blk_in = build_block(req_piggyback, req_byte_units, req_cluster,
    req_cluster_valid, req_interval_usage_code, req_size,
    req_scheduled_identifier, req_embedded_identifier,
    req_embedded_present, req_start_minislot, req_session);

  two_entry_buffer #(
    .WIDTH(BLK_BITS),
    .DEPTH(2)
  ) u_req_buf (
    .clk(clk),
    .rst_n(rst_n),
    .s_valid(b_s_valid),
    .s_ready(b_s_ready),
    .s_data(blk_in),
    .m_valid(b_m_valid),
    .m_ready(b_m_ready),
    .m_data(b_m_data)
  );

  assign more = b_m_valid && (r_reg.nblk < NB_W'(MAX_BLK));
  assign tmr_done = (r_reg.tmr == TM_W'(FLUSH_CYC));

  assign m_bad = !(map_seg_begin && map_seg_end &&
    (map_seg_count == ONE_SEGMENT));
  assign m_skip = map_first ? m_bad : r_reg.m_skip;
  assign m_pos = map_first ? '0 : r_reg.m_pos;
  assign m_ph = map_first ? 2'h0 : r_reg.m_ph;
  assign m_is_null = (m_ph == 2'h3) &&
    (usage_of({r_reg.m_sh, map_data}) == NULL_USAGE_CODE);

  assign probe_in_ready = !r_reg.po_v || probe_out_ready;
  assign p_take = probe_in_valid && probe_in_ready;
  assign p_pkt_end = probe_in_end || (r_reg.p_cnt == PC_W'(PROBE_MAX - 1));

  always_comb begin
    r_next = r_reg;
    b_m_ready = 1'b0;
    r_next.drop_p = req_valid && drop;
    r_next.mo_v = 1'b0;
    r_next.m_err = 1'b0;
    r_next.m_null = 1'b0;
    r_next.p_err = 1'b0;
    if (r_reg.st != REQ_IDLE && !tmr_done) begin
      r_next.tmr = TM_W'(r_reg.tmr + 1'b1);
    end
    // blocks from all channels, one segment
    case (r_reg.st)
      REQ_IDLE: begin
        if (b_m_valid) begin
          b_m_ready = 1'b1;
          r_next.blk = b_m_data;
          r_next.idx = 4'h0;
          r_next.nblk = NB_W'(1);
          r_next.tmr = '0;
          r_next.first = 1'b1;
          r_next.st = REQ_SEND;
        end
      end
      REQ_SEND: begin
        if (rq_out_ready) begin
          r_next.blk = r_reg.blk << 8;
          r_next.first = 1'b0;
          r_next.idx = 4'(r_reg.idx + 1'b1);
          if (r_reg.idx == 4'(BLK_BYTES - 2)) begin
            r_next.st = REQ_HOLD;
          end
        end
      end
      REQ_HOLD: begin
        if (more) begin
          r_next.endpkt = 1'b0;
          r_next.st = REQ_LAST;
        end else if (tmr_done || r_reg.nblk == NB_W'(MAX_BLK)) begin
          r_next.endpkt = 1'b1;
          r_next.st = REQ_LAST;
        end
      end
      REQ_LAST: begin
        if (rq_out_ready) begin
          r_next.first = 1'b0;
          if (r_reg.endpkt) begin
            r_next.st = REQ_IDLE;
          end else begin
            b_m_ready = 1'b1;
            r_next.blk = b_m_data;
            r_next.idx = 4'h0;
            r_next.nblk = NB_W'(r_reg.nblk + 1'b1);
            r_next.st = REQ_SEND;
          end
        end
      end
      default: begin
        r_next.st = REQ_IDLE;
      end
    endcase

    if (map_valid) begin
      r_next.m_skip = m_skip;
      if (map_first && m_bad) begin
        r_next.m_err = 1'b1;
      end
      if (!m_skip) begin
        r_next.mo_v = 1'b1;
        r_next.mo_d = map_data;
        r_next.mo_f = map_first;
        r_next.mo_l = map_last;
        r_next.mo_ch = map_channel;
        r_next.m_pos = MP_W'(m_pos + 1'b1);
        if (m_pos >= MP_W'(ELEM_OFS)) begin
          r_next.m_ph = 2'(m_ph + 1'b1);
          r_next.m_sh = {r_reg.m_sh[15:0], map_data};
          if (m_is_null) begin
            r_next.mo_l = 1'b1;
            r_next.m_null = 1'b1;
            r_next.m_skip = 1'b1;
          end
        end else begin
          r_next.m_ph = 2'h0;
        end
        if (m_pos == MP_W'(MAP_MAX - 1) && !map_last && !m_is_null) begin
          r_next.mo_l = 1'b1;
          r_next.m_err = 1'b1;
          r_next.m_skip = 1'b1;
        end
      end
    end

    if (r_reg.po_v && probe_out_ready) begin
      r_next.po_v = 1'b0;
    end
    if (p_take) begin
      r_next.po_v = 1'b1;
      r_next.po_d = probe_in_data;
      r_next.po_h = probe_in_hdr;
      r_next.po_f = (r_reg.p_cnt == '0);
      r_next.po_l = p_pkt_end;
      r_next.po_us = !r_reg.p_mid;
      r_next.po_ue = probe_in_end;
      r_next.p_cnt = p_pkt_end ? '0 : PC_W'(r_reg.p_cnt + 1'b1);
      r_next.p_mid = !probe_in_end;
      if (!r_reg.p_mid && !probe_in_hdr) begin
        r_next.p_err = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign req_dropped = r_reg.drop_p;
  assign rq_out_valid = (r_reg.st == REQ_SEND) || (r_reg.st == REQ_LAST);
  assign rq_out_data = r_reg.blk[BLK_BITS-1 -: 8];
  assign rq_out_first = r_reg.first;
  assign rq_out_last = (r_reg.st == REQ_LAST) && r_reg.endpkt;
  assign rq_out_blocks = 8'(r_reg.nblk);
  assign rq_seg_flags = SEG_BEGIN_END;
  assign mo_valid = r_reg.mo_v;
  assign mo_data = r_reg.mo_d;
  assign mo_first = r_reg.mo_f;
  assign mo_last = r_reg.mo_l;
  assign mo_channel = r_reg.mo_ch;
  assign map_null_seen = r_reg.m_null;
  assign map_error = r_reg.m_err;
  assign probe_out_valid = r_reg.po_v;
  assign probe_out_data = r_reg.po_d;
  assign probe_out_hdr = r_reg.po_h;
  assign probe_out_first = r_reg.po_f;
  assign probe_out_last = r_reg.po_l;
  assign probe_out_unit_start = r_reg.po_us;
  assign probe_out_unit_end = r_reg.po_ue;
  assign probe_error = r_reg.p_err;
endmodule

// ==== verilog/framer_pkg.sv ====
// Constants and types for the upstream request, map and probe framer
package framer_pkg;
  localparam int CLK_FREQ_MHZ = 25;
  localparam int FLUSH_TIME_US = 100;
  localparam int FLUSH_CYCLES = FLUSH_TIME_US * CLK_FREQ_MHZ;
  localparam int BLK_BYTES = 16;
  localparam int BLK_BITS = 128;
  localparam int BLK_PAD_BITS = 7;
  localparam int MAX_BLOCKS = 64;
  localparam int MAP_MAX_BYTES = 1500;
  localparam int MAP_ELEM_OFFSET = 16;
  localparam int PROBE_PKT_MAX = 1024;
  localparam int ST_VALID_BIT = 2;
  localparam int ST_UNITS_BIT = 1;
  localparam int ST_TYPE_BIT = 0;
  localparam logic [1:0] HDR_VERSION_1 = 2'h0;
  localparam logic [1:0] SEG_BEGIN_END = 2'h3;
  localparam logic [3:0] NULL_USAGE_CODE = 4'h7;
  localparam logic [7:0] ONE_SEGMENT = 8'h01;

  typedef enum logic [1:0] {
    REQ_IDLE = 2'b00,
    REQ_SEND = 2'b01,
    REQ_HOLD = 2'b11,
    REQ_LAST = 2'b10
  } req_state_t;
endpackage

// ==== verilog/two_entry_buffer.sv ====
// Small ring buffer with valid and ready on both sides
`timescale 1ns/10ps
module two_entry_buffer import framer_pkg::*; #(
  parameter int WIDTH = 128,
  parameter int DEPTH = 2
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic s_valid,
  output logic s_ready,
  input wire logic [WIDTH-1:0] s_data,
  output logic m_valid,
  input wire logic m_ready,
  output logic [WIDTH-1:0] m_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [CW-1:0] cnt;
  } buf_state_t;

  buf_state_t r_reg;
  buf_state_t r_next;
  logic push;
  logic pop;

  function automatic logic [AW-1:0] wrap_inc(input logic [AW-1:0] p);
    wrap_inc = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
  endfunction

  assign s_ready = (r_reg.cnt != CW'(DEPTH));
  assign m_valid = (r_reg.cnt != '0);
  assign m_data = r_reg.mem[r_reg.rp];
  assign push = s_valid && s_ready;
  assign pop = m_valid && m_ready;

  always_comb begin
    r_next = r_reg;
    if (push) begin
      r_next.mem[r_reg.wp] = s_data;
      r_next.wp = wrap_inc(r_reg.wp);
    end
    if (pop) begin
      r_next.rp = wrap_inc(r_reg.rp);
    end
    if (push && !pop) begin
      r_next.cnt = CW'(r_reg.cnt + 1'b1);
    end else if (pop && !push) begin
      r_next.cnt = CW'(r_reg.cnt - 1'b1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end
endmodule

// ==== bench/framer_chk.sv ====
// Port checker for the request, map and probe framer
`timescale 1ns/10ps
module framer_chk import framer_pkg::*; #(
  parameter int MAX_BLK = 3
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic req_piggyback,
  input wire logic req_frag_concat,
  input wire logic req_dropped,
  input wire logic rq_out_valid,
  input wire logic [7:0] rq_out_data,
  input wire logic rq_out_first,
  input wire logic rq_out_last,
  input wire logic [7:0] rq_out_blocks,
  input wire logic [1:0] rq_seg_flags,
  input wire logic map_valid,
  input wire logic map_first,
  input wire logic map_seg_begin,
  input wire logic map_seg_end,
  input wire logic [7:0] map_seg_count,
  input wire logic mo_valid,
  input wire logic mo_first,
  input wire logic mo_last,
  input wire logic map_null_seen,
  input wire logic map_error,
  input wire logic probe_out_valid,
  input wire logic probe_out_first,
  input wire logic probe_out_unit_start
);
  logic take;
  logic map_ok;
  assign take = req_valid && req_ready;
  assign map_ok = map_seg_begin && map_seg_end && map_seg_count == 8'h01;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_flags_fixed: assert property (rq_seg_flags == 2'h3)
    else $error("segment flags wrong");
  a_drop_pulse: assert property (
    take && req_piggyback && req_frag_concat |=> req_dropped)
    else $error("piggyback not dropped");
  a_keep_standalone: assert property (
    take && !req_piggyback |=> !req_dropped)
    else $error("standalone dropped");
  a_status_version: assert property (
    rq_out_valid && rq_out_first |-> rq_out_data[7:6] == 2'h0)
    else $error("bad header version");
  a_last_count: assert property (
    rq_out_valid && rq_out_last |-> rq_out_blocks >= 8'h01
      && rq_out_blocks <= MAX_BLK)
    else $error("bad block count");
  a_map_take: assert property (
    map_valid && map_first && map_ok |=> mo_valid && mo_first)
    else $error("good map not forwarded");
  a_map_refuse: assert property (
    map_valid && map_first && !map_ok |=> map_error && !mo_valid)
    else $error("bad map forwarded");
  a_null_stop: assert property (
    map_null_seen && !(map_valid && map_first) |-> mo_last ##1 !mo_valid)
    else $error("bytes after null element");
  a_unit_alone: assert property (
    probe_out_valid && probe_out_unit_start |-> probe_out_first)
    else $error("unit shares a packet");
  cover property (req_dropped);
  cover property (map_null_seen);
  cover property (rq_out_last && rq_out_blocks == 8'(MAX_BLK));
endmodule
bind upstream_request_map_framer framer_chk #(.MAX_BLK(MAX_BLK)) chk_i (.*);

// ==== bench/sched_core_model.sv ====
// Scheduling core model: request and probe sink, map source
`timescale 1ns/10ps
module sched_core_model (
  input wire logic clk,
  input wire logic slow,
  output logic rq_out_ready,
  output logic probe_out_ready,
  output logic map_valid,
  output logic [7:0] map_data,
  output logic map_first,
  output logic map_last,
  output logic [7:0] map_channel,
  output logic map_seg_begin,
  output logic map_seg_end,
  output logic [7:0] map_seg_count
);
  logic [1:0] ph = 2'h0;
  initial begin
    {map_valid, map_first, map_last, map_seg_begin, map_seg_end} = 5'h00;
    {map_data, map_channel, map_seg_count} = 24'h00_0000;
    rq_out_ready = 1'h1;
    probe_out_ready = 1'h1;
  end
  always @(posedge clk) begin
    ph <= ph + 2'h1;
    rq_out_ready <= #1 !slow || ph == 2'h0;
    probe_out_ready <= #1 !slow || ph == 2'h2;
  end
  // segment flags and count from be and cnt, null element, trailing junk
  task automatic send_map(input logic [7:0] ch, input logic [1:0] be,
      input logic [7:0] cnt, input int nel);
    int n;
    int e;
    logic [31:0] w;
    n = 20 + 4 * nel;
    for (int i = 0; i < n; i++) begin
      e = (i - 16) / 4;
      w = {14'h0155, e == nel - 1 ? 4'h7 : 4'(e % 7), 14'h02aa};
      map_data = i < 16 ? 8'(i) : w[31 - 8 * (i % 4) -: 8];
      map_valid = 1'h1;
      map_first = i == 0;
      map_last = i == n - 1;
      map_channel = ch;
      {map_seg_begin, map_seg_end} = be;
      map_seg_count = cnt;
      @(posedge clk) #1;
    end
    map_valid = 1'h0;
    map_data = ~map_data;
  endtask
endmodule

// ==== bench/upstream_request_map_framer_bench.sv ====
// Self-checking bench for the request, map and probe framer
`timescale 1ns/10ps
module upstream_request_map_framer_bench;
  import framer_pkg::*;
  localparam int MB = 3;
  localparam int FC = 20;
  localparam int MM = 40;
  bit clk, rst_n, slow, req_valid, req_piggyback, req_frag_concat;
  bit req_byte_units, req_cluster_valid, req_embedded_present;
  bit probe_in_valid, probe_in_hdr, probe_in_end;
  bit [2:0] req_cluster;
  bit [3:0] req_interval_usage_code;
  bit [15:0] req_size;
  bit [13:0] req_scheduled_identifier, req_embedded_identifier;
  bit [31:0] req_start_minislot, req_session;
  bit [7:0] probe_in_data;
  logic rq_out_ready, probe_out_ready, map_valid, map_first, map_last;
  logic map_seg_begin, map_seg_end, req_ready, req_dropped, rq_out_valid;
  logic rq_out_first, rq_out_last, mo_valid, mo_first, mo_last;
  logic map_null_seen, map_error, probe_in_ready, probe_out_valid;
  logic probe_out_hdr, probe_out_first, probe_out_last, probe_error;
  logic probe_out_unit_start, probe_out_unit_end;
  logic [7:0] map_data, map_channel, map_seg_count, rq_out_data;
  logic [7:0] rq_out_blocks, mo_data, mo_channel, probe_out_data;
  logic [1:0] rq_seg_flags;
  logic [31:0] seed = 32'hcac8_4cd5;
  logic [31:0] r;
  logic [7:0] exp[$], mch;
  logic [9:0] pq[$];
  int error_cnt, check_count, sb, nseg, n0, mo_n, mo_ln, err_n, pk, us;
  int pl, pe;
  bit rl;
  upstream_request_map_framer #(.MAX_BLK(MB), .FLUSH_CYC(FC), .PROBE_MAX(8),
    .MAP_MAX(MM)) uut (.*);
  sched_core_model core (.*);
  always #20 clk = ~clk;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [127:0] blk();
    return {2'h0, req_cluster, req_cluster_valid, req_byte_units,
      req_piggyback, 1'h0, req_interval_usage_code, req_size,
      req_scheduled_identifier,
      req_embedded_present ? req_embedded_identifier : 14'h0000,
      req_start_minislot, req_session, 7'h00};
  endfunction
  task automatic tick();
    @(posedge clk) #1;
  endtask
  task automatic chk(input bit ok, input string m);
    check_count++;
    if (!ok) begin
      error_cnt++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask
  task automatic send_req(input logic p, input logic f);
    logic [127:0] b;
    req_piggyback = p;
    req_frag_concat = f;
    {req_cluster, req_cluster_valid, req_byte_units, req_embedded_present,
      req_interval_usage_code, req_size} = 26'(rnd());
    {req_scheduled_identifier, req_embedded_identifier} = 28'(rnd());
    req_start_minislot = rnd();
    req_session = rnd();
    req_valid = 1'h1;
    b = blk();
    if (!(p && f))
      for (int i = 15; i >= 0; i--)
        exp.push_back(b[8 * i +: 8]);
    do @(posedge clk); while (req_ready !== 1'h1);
    #1;
  endtask
  task automatic probe_unit(input int n, input bit h);
    for (int i = 0; i < n; i++) begin
      probe_in_valid = 1'h1;
      probe_in_hdr = h && i == 0;
      probe_in_end = i == n - 1;
      probe_in_data = 8'(rnd());
      pq.push_back({probe_in_hdr, probe_in_end, probe_in_data});
      do @(posedge clk); while (probe_in_ready !== 1'h1);
      #1;
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  always @(posedge clk) if (rst_n) begin
    if (req_valid && req_ready !== 1'h1) rl = 1'h1;
    if (rq_out_valid === 1'h1 && rq_out_ready) begin
      chk(exp.size() > 0 && rq_out_data === exp.pop_front(), "req byte");
      chk(rq_out_first === (sb == 0), "first flag");
      sb++;
      if (rq_out_last === 1'h1) begin
        chk(rq_out_blocks * 16 == sb && rq_out_blocks <= MB, "seg");
        sb = 0;
        nseg++;
      end
    end
    if (mo_valid === 1'h1) begin
      mo_n++;
      if (mo_last === 1'h1) mo_ln = mo_n;
      chk(mo_channel === mch, "map channel");
      chk(mo_first === (mo_n == 1), "map first");
      if (mo_n <= 16) chk(mo_data === 8'(mo_n - 1), "map data");
    end
    if (map_error === 1'h1) err_n++;
    if (probe_error === 1'h1) pe++;
    if (probe_out_valid === 1'h1 && probe_out_ready) begin
      chk(pq.size() > 0 && {probe_out_hdr, probe_out_unit_end,
        probe_out_data} === pq.pop_front(), "probe");
      if (probe_out_first === 1'h1) pk++;
      if (probe_out_last === 1'h1) pl++;
      if (probe_out_unit_start === 1'h1) us++;
    end
  end
  initial begin
    #(40 * 20000);
    error_cnt++;
    wrap_up();
  end
  initial begin
    repeat (6) @(posedge clk);
    #1 rst_n = 1'h1;
    slow = 1'h1;
    send_req(1'h1, 1'h1);
    send_req(1'h0, 1'h1);
    send_req(1'h1, 1'h0);
    for (int i = 0; i < 7; i++) begin
      r = rnd();
      send_req(r[0], r[1]);
    end
    req_valid = 1'h0;
    for (int k = 0; k < 3000 && (exp.size() > 0 || sb > 0); k++) tick();
    chk(exp.size() == 0 && rl, "burst drain");
    $display("request burst test done");
    slow = 1'h0;
    n0 = nseg;
    send_req(1'h0, 1'h0);
    req_valid = 1'h0;
    for (int k = 0; k < FC + 40 && nseg == n0; k++) tick();
    chk(nseg == n0 + 1 && exp.size() == 0, "flush");
    $display("flush test done");
    for (int c = 0; c < 3; c++) begin
      mch = 8'(c + 4);
      mo_n = 0;
      err_n = 0;
      core.send_map(mch, 2'h3, 8'h01, 1 + c * 3);
      repeat (2) tick();
      chk(mo_n == (c < 2 ? 20 + 12 * c : MM) && mo_ln == mo_n,
        "map length");
      chk(err_n == (c == 2 ? 1 : 0), "map overflow");
    end
    for (int c = 0; c < 3; c++) begin
      mo_n = 0;
      err_n = 0;
      core.send_map(mch, c < 2 ? 2'(c + 1) : 2'h3, c < 2 ? 8'h01 : 8'h02, 2);
      repeat (2) tick();
      chk(mo_n == 0 && err_n == 1, "bad table");
    end
    $display("map test done");
    slow = 1'h1;
    probe_unit(12, 1'h1);
    probe_unit(3, 1'h1);
    probe_unit(2, 1'h0);
    probe_in_valid = 1'h0;
    for (int k = 0; k < 200 && pq.size() > 0; k++) tick();
    repeat (2) tick();
    chk(pq.size() == 0 && pk == 4 && pl == 4 && us == 3 && pe == 1,
      "probe packets");
    $display("probe test done");
    wrap_up();
  end
endmodule
